/* File: src/ssf_top.sv */
// Serial port slave with status flags, FIFOs and an AHB-Lite register slave.
// Assumes an external serial master (mode 0, MSB first) driving the link pins.
`timescale 1ns/1ps
`default_nettype none
module ssf_top
	import ssf_pkg::*;
#(
	parameter int WORD_W = 8,
	parameter int DEPTH = 16
)
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic LINK_SCK,
	input wire logic LINK_SS_N,
	input wire logic LINK_SDI,
	output logic LINK_SDO,
	output logic LINK_SDO_OE,
	output logic IRQ
);
	localparam int CW = $clog2(DEPTH) + 1;

	if (WORD_W < 2 || WORD_W > 32)
		$error("ssf_top: WORD_W must lie in 2..32");
	if (CW > CNT_W)
		$error("ssf_top: DEPTH too large for the count fields");

	// Link synchroniser; stage one feeds stage two only
	ssf_link_type link_s1_reg, link_s2_reg, link_s3_reg;
	logic sck_rise, sck_fall, sel_start, sel_end;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			link_s1_reg <= '{sck: 1'b0, ss_n: 1'b1, sdi: 1'b0};
			link_s2_reg <= '{sck: 1'b0, ss_n: 1'b1, sdi: 1'b0};
			link_s3_reg <= '{sck: 1'b0, ss_n: 1'b1, sdi: 1'b0};
		end
		else
		begin
			link_s1_reg <= '{sck: LINK_SCK, ss_n: LINK_SS_N, sdi: LINK_SDI};
			link_s2_reg <= link_s1_reg;
			link_s3_reg <= link_s2_reg;
		end
	end

	assign sck_rise = link_s2_reg.sck && !link_s3_reg.sck;
	assign sck_fall = !link_s2_reg.sck && link_s3_reg.sck;
	assign sel_start = !link_s2_reg.ss_n && link_s3_reg.ss_n;
	assign sel_end = link_s2_reg.ss_n && !link_s3_reg.ss_n;

	// Registers, link state and FIFO wiring
	ssf_ctrl_type ctrl_reg;
	ssf_req_type req_reg;
	logic [IRQ_W-1:0] irq_status_reg, irq_en_reg;
	logic frm_err_reg, rov_reg, tur_reg;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg, hresp_reg, irq_reg;
	ssf_link_state_type state_reg;
	logic [$clog2(WORD_W)-1:0] bit_cnt_reg;
	logic [WORD_W-1:0] rx_shift_reg, tx_shift_reg;
	logic loaded_reg, sdo_reg, sdo_oe_reg;
	logic rx_wr_ready, rx_rd_valid, rx_empty, tx_wr_ready, tx_rd_valid, tx_empty_ptr;
	logic [WORD_W-1:0] rx_rd_data, tx_rd_data;
	logic [CW-1:0] rx_count, tx_count;
	logic addr_phase, wr_act, rx_pop, tx_push, rx_accept, tx_accept;
	logic word_done, load_now, rx_push, rov_event, frm_event, tur_event;
	logic [WORD_W-1:0] rx_word;
	logic [31:0] status_word;
	logic [IRQ_W-1:0] irq_events;

	assign addr_phase = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == 2'h3);
	assign wr_act = req_reg.valid && req_reg.write;
	// Outside enhanced mode each buffer holds a single word
	assign rx_accept = rx_wr_ready && (ctrl_reg.enh || rx_count == '0);
	assign tx_accept = tx_wr_ready && (ctrl_reg.enh || tx_count == '0);
	assign rx_pop = addr_phase && !HWRITE && HADDR[7:0] == OFS_DATA && rx_rd_valid;
	assign tx_push = wr_act && req_reg.addr == OFS_DATA && tx_accept;
	assign word_done = ctrl_reg.on && state_reg == LS_ACTIVE && !sel_end && sck_rise
		&& bit_cnt_reg == ($clog2(WORD_W))'(WORD_W - 1);
	assign load_now = (ctrl_reg.on && state_reg == LS_IDLE && sel_start) || word_done;
	assign rx_word = {rx_shift_reg[WORD_W-2:0], link_s2_reg.sdi};
	assign rx_push = word_done && rx_accept;
	assign rov_event = word_done && !rx_accept;
	assign frm_event = ctrl_reg.on && ctrl_reg.frm && state_reg == LS_ACTIVE && sel_end
		&& bit_cnt_reg != '0;
	assign tur_event = load_now && ctrl_reg.frm && !tx_rd_valid;

	ssf_fifo #(
		.W(WORD_W),
		.DEPTH(DEPTH)
	) u_rx_fifo (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.flush(!ctrl_reg.on),
		.wr_valid(rx_push),
		.wr_ready(rx_wr_ready),
		.wr_data(rx_word),
		.rd_valid(rx_rd_valid),
		.rd_ready(rx_pop),
		.rd_data(rx_rd_data),
		.count(rx_count),
		.ptr_equal(rx_empty)
	);

	ssf_fifo #(
		.W(WORD_W),
		.DEPTH(DEPTH)
	) u_tx_fifo (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.flush(!ctrl_reg.on),
		.wr_valid(tx_push),
		.wr_ready(tx_wr_ready),
		.wr_data(HWDATA[WORD_W-1:0]),
		.rd_valid(tx_rd_valid),
		.rd_ready(load_now),
		.rd_data(tx_rd_data),
		.count(tx_count),
		.ptr_equal(tx_empty_ptr)
	);

	always_comb
	begin
		status_word = '0;
		status_word[RXCNT_LSB +: CNT_W] = CNT_W'(rx_count);
		status_word[TXCNT_LSB +: CNT_W] = CNT_W'(tx_count);
		status_word[FRAME_ERROR_FLAG_BIT] = frm_err_reg;
		status_word[BUSY_BIT] = state_reg == LS_ACTIVE || loaded_reg;
		status_word[TUR_BIT] = tur_reg;
		status_word[SHIFT_REG_EMPTY_FLAG_BIT] = !loaded_reg;
		status_word[ROV_BIT] = rov_reg;
		status_word[RBE_BIT] = rx_empty;
		status_word[TBE_BIT] = tx_empty_ptr;
		status_word[TBF_BIT] = !tx_accept;
		status_word[RBF_BIT] = !rx_accept;
	end

	function automatic logic [31:0] read_mux(input logic [7:0] addr);
		unique case (addr)
			OFS_STATUS: read_mux = status_word;
			OFS_CONTROL: read_mux = 32'(ctrl_reg);
			OFS_DATA: read_mux = rx_rd_valid ? 32'(rx_rd_data) : 32'h0000_0000;
			OFS_IRQ_STATUS: read_mux = 32'(irq_status_reg);
			OFS_IRQ_ENABLE: read_mux = 32'(irq_en_reg);
			default: read_mux = 32'h0000_0000;
		endcase
	endfunction : read_mux

	// Bus slave; zero wait states, always OKAY
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			req_reg <= REQ_RESET;
			hrdata_reg <= RDATA_RESET;
			hreadyout_reg <= 1'b1;
			hresp_reg <= HRESP_OKAY;
		end
		else
		begin
			req_reg <= '{valid: addr_phase, write: HWRITE, addr: HADDR[7:0]};
			hreadyout_reg <= 1'b1;
			hresp_reg <= HRESP_OKAY;
			if (addr_phase && !HWRITE)
				hrdata_reg <= read_mux(HADDR[7:0]);
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			ctrl_reg <= CTRL_RESET;
			irq_en_reg <= IRQ_EN_RESET;
		end
		else if (wr_act)
		begin
			if (req_reg.addr == OFS_CONTROL)
				ctrl_reg <= '{frm: HWDATA[CTL_FRM_BIT], enh: HWDATA[CTL_ENH_BIT],
					on: HWDATA[CTL_ON_BIT]};
			if (req_reg.addr == OFS_IRQ_ENABLE)
				irq_en_reg <= HWDATA[IRQ_W-1:0];
		end
	end

	// Status flags; a hardware set wins over a software clear
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			frm_err_reg <= 1'b0;
			rov_reg <= 1'b0;
		end
		else
		begin
			if (frm_event)
				frm_err_reg <= 1'b1;
			else if (wr_act && req_reg.addr == OFS_STATUS && !HWDATA[FRAME_ERROR_FLAG_BIT])
				frm_err_reg <= 1'b0;
			if (rov_event)
				rov_reg <= 1'b1;
			else if (wr_act && req_reg.addr == OFS_STATUS && !HWDATA[ROV_BIT])
				rov_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || !ctrl_reg.on)
			tur_reg <= 1'b0;
		else if (tur_event)
			tur_reg <= 1'b1;
	end

	assign irq_events[IRQ_RX_BIT] = rx_push;
	assign irq_events[IRQ_ROV_BIT] = rov_event;
	assign irq_events[IRQ_FRM_BIT] = frm_event;
	assign irq_events[IRQ_TUR_BIT] = tur_event;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			irq_status_reg <= '0;
			irq_reg <= 1'b0;
		end
		else
		begin
			if (wr_act && req_reg.addr == OFS_IRQ_CLEAR)
				irq_status_reg <= (irq_status_reg & ~HWDATA[IRQ_W-1:0]) | irq_events;
			else
				irq_status_reg <= irq_status_reg | irq_events;
			// One cycle behind the status bits
			irq_reg <= |(irq_status_reg & irq_en_reg);
		end
	end

	// Link state machine and receive shifter
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || !ctrl_reg.on)
		begin
			state_reg <= LS_IDLE;
			bit_cnt_reg <= '0;
			rx_shift_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				LS_IDLE:
				begin
					bit_cnt_reg <= '0;
					if (sel_start)
						state_reg <= LS_ACTIVE;
				end
				LS_ACTIVE:
				begin
					if (sel_end)
					begin
						state_reg <= LS_IDLE;
						bit_cnt_reg <= '0;
					end
					else if (sck_rise)
					begin
						rx_shift_reg <= rx_word;
						if (word_done)
							bit_cnt_reg <= '0;
						else
							bit_cnt_reg <= bit_cnt_reg + 1'b1;
					end
				end
			endcase
		end
	end

	// Transmit shifter; an empty buffer sends zeros
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || !ctrl_reg.on)
		begin
			tx_shift_reg <= '0;
			loaded_reg <= 1'b0;
			sdo_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end
		else
		begin
			sdo_oe_reg <= state_reg == LS_ACTIVE && !sel_end;
			if (load_now)
			begin
				tx_shift_reg <= tx_rd_valid ? tx_rd_data : '0;
				sdo_reg <= tx_rd_valid ? tx_rd_data[WORD_W-1] : 1'b0;
				loaded_reg <= tx_rd_valid;
			end
			else if (sel_end)
				loaded_reg <= 1'b0;
			else if (state_reg == LS_ACTIVE && sck_fall && bit_cnt_reg != '0)
			begin
				tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
				sdo_reg <= tx_shift_reg[WORD_W-2];
			end
		end
	end

	assign HRDATA = hrdata_reg;
	assign HREADYOUT = hreadyout_reg;
	assign HRESP = hresp_reg;
	assign LINK_SDO = sdo_reg;
	assign LINK_SDO_OE = sdo_oe_reg;
	assign IRQ = irq_reg;

endmodule : ssf_top
`default_nettype wire

/* File: src/ssf_pkg.sv */
// Constants and carrier types of the serial port status and flag block.
// Assumes a single AHB-Lite master and an external serial master on the link pins.
package ssf_pkg;

	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

	localparam int CNT_W = 5;
	localparam int RXCNT_LSB = 24;
	localparam int TXCNT_LSB = 16;
	localparam int FRAME_ERROR_FLAG_BIT = 12;
	localparam int BUSY_BIT = 11;
	localparam int TUR_BIT = 8;
	localparam int SHIFT_REG_EMPTY_FLAG_BIT = 7;
	localparam int ROV_BIT = 6;
	localparam int RBE_BIT = 5;
	localparam int TBE_BIT = 3;
	localparam int TBF_BIT = 1;
	localparam int RBF_BIT = 0;

	localparam int CTL_ON_BIT = 0;
	localparam int CTL_ENH_BIT = 1;
	localparam int CTL_FRM_BIT = 2;

	localparam int IRQ_W = 4;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_ROV_BIT = 1;
	localparam int IRQ_FRM_BIT = 2;
	localparam int IRQ_TUR_BIT = 3;

	localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam int SYNC_STAGES = 2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic frm;
		logic enh;
		logic on;
	} ssf_ctrl_type;

	localparam ssf_ctrl_type CTRL_RESET = '{frm: 1'b0, enh: 1'b0, on: 1'b0};

	typedef struct packed {
		logic sck;
		logic ss_n;
		logic sdi;
	} ssf_link_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} ssf_req_type;

	localparam ssf_req_type REQ_RESET = '{valid: 1'b0, write: 1'b0, addr: 8'h00};

	typedef enum logic [0:0] {
		LS_IDLE = 1'b0,
		LS_ACTIVE = 1'b1
	} ssf_link_state_type;

endpackage : ssf_pkg

/* File: src/ssf_fifo.sv */
// Word FIFO with extended pointers used for both serial directions.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none
module ssf_fifo
	import ssf_pkg::*;
#(
	parameter int W = 8,
	parameter int DEPTH = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data,
	output logic [$clog2(DEPTH):0] count,
	output logic ptr_equal
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("ssf_fifo: DEPTH must be a power of two, at least 2");

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;

	assign ptr_equal = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign wr_ready = !full;
	assign rd_valid = !ptr_equal;
	assign rd_data = mem[rd_ptr_reg[AW-1:0]];
	assign count = wr_ptr_reg - rd_ptr_reg;

	always_ff @(posedge clk)
	begin
		if (wr_valid && !full)
			mem[wr_ptr_reg[AW-1:0]] <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (wr_valid && !full)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (rd_ready && !ptr_equal)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule : ssf_fifo
`default_nettype wire

/* File: bench/ssf_monitor.sv */
// Port checker of the serial status block.
// Assumes one AHB-Lite master; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module ssf_monitor
	import ssf_pkg::*;
#(
	parameter int DEPTH = 16
)
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic LINK_SS_N,
	input wire logic LINK_SDO_OE
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	logic rd_t;
	assign rd_t = HSEL && HREADY && HTRANS[1] && !HWRITE;
	sequence st_rd;
		rd_t && HADDR[7:0] == OFS_STATUS;
	endsequence
	// Sync chain plus output register
	sequence ss_high;
		LINK_SS_N [*6];
	endsequence
	ready_high_a: assert property (HREADYOUT) else $error("ready low");
	resp_okay_a: assert property (HRESP == HRESP_OKAY) else $error("response not okay");
	rsvd_zero_a: assert property (st_rd |=> (HRDATA & 32'hE0E0_E610) == 32'h0)
		else $error("reserved status bits set");
	empty_count_a: assert property (st_rd |=> HRDATA[RBE_BIT] == (HRDATA[28:24] == 5'h00))
		else $error("empty flag disagrees with count");
	count_range_a: assert property (st_rd |=> HRDATA[28:24] <= DEPTH && HRDATA[20:16] <= DEPTH)
		else $error("element count out of range");
	busy_shift_a: assert property (st_rd |=> HRDATA[SHIFT_REG_EMPTY_FLAG_BIT] || HRDATA[BUSY_BIT])
		else $error("loaded shift register while idle");
	rdata_hold_a: assert property (!rd_t |=> $stable(HRDATA)) else $error("read data moved");
	oe_idle_a: assert property (ss_high |-> !LINK_SDO_OE) else $error("data out driven unselected");
	unmapped_zero_a: assert property (rd_t && HADDR[7:0] >= 8'h18 |=> HRDATA == 32'h0)
		else $error("unmapped read not zero");
	cover property (st_rd ##1 HRDATA[ROV_BIT]);
endmodule : ssf_monitor
bind ssf_top ssf_monitor #(.DEPTH(DEPTH)) i_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINK_SS_N(LINK_SS_N), .LINK_SDO_OE(LINK_SDO_OE));
`default_nettype wire

/* File: bench/ssf_link_master.sv */
// External serial master, mode 0, MSB first.
// Assumes the bench calls its tasks; clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module ssf_link_master
#(
	parameter int HALF_NS = 40
)
(
	output logic sck,
	output logic ss_n,
	output logic sdi,
	input wire logic sdo
);
	initial
	begin
		sck = 1'b0;
		ss_n = 1'b1;
		sdi = 1'b0;
	end
	// Odd offset keeps phase unrelated to the system clock
	task start;
		#3;
		ss_n = 1'b0;
		#(HALF_NS);
	endtask : start
	task word(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nbits; i--)
		begin
			sdi = tx[i];
			#(HALF_NS) sck = 1'b1;
			rx[i] = sdo;
			#(HALF_NS) sck = 1'b0;
		end
	endtask : word
	// Released data line shows a changed level
	task stop;
		#(HALF_NS);
		ss_n = 1'b1;
		sdi = ~sdi;
	endtask : stop
endmodule : ssf_link_master
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench of the serial status block.
// Assumes the checker is bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module tb
	import ssf_pkg::*;
;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic HSEL = 1'b0;
	logic HWRITE = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	wire logic [31:0] HRDATA;
	wire logic HREADYOUT, HRESP, LINK_SCK, LINK_SS_N, LINK_SDI, LINK_SDO, LINK_SDO_OE, IRQ;
	int failures = 0;
	int n_compared = 0;
	logic [31:0] q;
	logic [7:0] r;
	always #2.5 CLK_SYS = ~CLK_SYS;
	ssf_top #(.WORD_W(8), .DEPTH(16)) i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.LINK_SCK(LINK_SCK), .LINK_SS_N(LINK_SS_N), .LINK_SDI(LINK_SDI), .LINK_SDO(LINK_SDO),
		.LINK_SDO_OE(LINK_SDO_OE), .IRQ(IRQ));
	wire logic link_miso;
	// A released data line reads inverted, so a late output enable shows up
	assign link_miso = LINK_SDO_OE ? LINK_SDO : !LINK_SDO;
	ssf_link_master i_link (.sck(LINK_SCK), .ss_n(LINK_SS_N), .sdi(LINK_SDI), .sdo(link_miso));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		HTRANS <= HTRANS_NONSEQ;
		HSEL <= 1'b1;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		@(posedge CLK_SYS);
		while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge CLK_SYS);
		while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
		q = HRDATA;
	endtask : bus
	task st(input logic [31:0] m, input logic [31:0] e, input string n);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(n, q & m, e);
	endtask : st
	// Gives the async link time to cross the sync chain
	task link_end;
		i_link.stop();
		repeat (10) @(posedge CLK_SYS);
	endtask : link_end
	task t_reset;
		st(32'hFFFF_FFFF, 32'h0000_00A8, "status");
		bus(1'b0, OFS_CONTROL, 32'h0);
		chk("control", q, 32'h0);
		bus(1'b0, 8'h18, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		st(32'hFFFF_FFFF, 32'h0000_00A8, "status write");
	endtask : t_reset
	task t_buffer;
		bus(1'b1, OFS_CONTROL, 32'h3);
		bus(1'b1, OFS_DATA, 32'hA5);
		bus(1'b1, OFS_DATA, 32'h5A);
		st(32'h001F_0000, 32'h0002_0000, "tx count");
		i_link.start();
		@(posedge CLK_SYS);
		st(32'h0000_0880, 32'h0000_0800, "busy");
		i_link.word(8'h3C, 8, r);
		chk("sdo first", {24'h0, r}, 32'hA5);
		i_link.word(8'hC3, 8, r);
		chk("sdo second", {24'h0, r}, 32'h5A);
		link_end();
		st(32'h1F00_08A0, 32'h0200_0080, "rx count");
		chk("irq masked", 32'(IRQ), 32'h0);
		bus(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk("irq status", q & 32'h1, 32'h1);
		bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge CLK_SYS);
		chk("irq raised", 32'(IRQ), 32'h1);
		bus(1'b0, OFS_DATA, 32'h0);
		chk("rx first", q & 32'hFF, 32'h3C);
		st(32'h1F00_0020, 32'h0100_0000, "rx one");
		bus(1'b0, OFS_DATA, 32'h0);
		chk("rx second", q & 32'hFF, 32'hC3);
		st(32'h1F00_0020, 32'h0000_0020, "rx empty");
		bus(1'b1, OFS_IRQ_CLEAR, 32'h1);
		repeat (2) @(posedge CLK_SYS);
		chk("irq cleared", 32'(IRQ), 32'h0);
		bus(1'b1, OFS_CONTROL, 32'h0);
	endtask : t_buffer
	task t_overflow;
		bus(1'b1, OFS_CONTROL, 32'h1);
		i_link.start();
		i_link.word(8'h11, 8, r);
		i_link.word(8'h22, 8, r);
		i_link.word(8'h33, 4, r);
		link_end();
		st(32'h0000_1040, 32'h0000_0040, "overflow");
		bus(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk("irq overflow", q & 32'h2, 32'h2);
		bus(1'b0, OFS_DATA, 32'h0);
		chk("kept word", q & 32'hFF, 32'h11);
		bus(1'b1, OFS_STATUS, 32'h40);
		st(32'h0000_0040, 32'h0000_0040, "overflow kept");
		bus(1'b1, OFS_STATUS, 32'h0);
		st(32'h0000_0040, 32'h0, "overflow clear");
		bus(1'b1, OFS_CONTROL, 32'h0);
	endtask : t_overflow
	task t_framed;
		bus(1'b1, OFS_CONTROL, 32'h5);
		i_link.start();
		i_link.word(8'h77, 8, r);
		i_link.word(8'h77, 4, r);
		link_end();
		st(32'h0000_1100, 32'h0000_1100, "frame flags");
		bus(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk("irq frame", q & 32'hC, 32'hC);
		bus(1'b1, OFS_STATUS, 32'h0);
		st(32'h0000_1100, 32'h0000_0100, "underrun kept");
		bus(1'b1, OFS_CONTROL, 32'h0);
		bus(1'b1, OFS_CONTROL, 32'h5);
		st(32'h0000_1100, 32'h0, "underrun cleared");
	endtask : t_framed
	task end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (5) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		@(posedge CLK_SYS);
		t_reset();
		t_buffer();
		t_overflow();
		t_framed();
		end_of_test();
	end
	// Whole run needs a few microseconds
	initial
	begin
		#100000;
		failures++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
